// >>> hw/packetizer_pkg.sv
package packetizer_pkg;
    // Register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_SIZE = 6'h08;
    localparam logic [5:0] REG_ROI_A = 6'h0C;
    localparam logic [5:0] REG_ROI_B = 6'h10;
    localparam logic [5:0] REG_INTEG_A = 6'h14;
    localparam logic [5:0] REG_INTEG_B = 6'h18;
    localparam logic [5:0] REG_FORMAT = 6'h1C;
    localparam logic [5:0] REG_REPLY_ARG = 6'h20;
    localparam logic [5:0] REG_REPLY_CMD = 6'h24;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Reply codes
    localparam logic [7:0] RSP_ACK = 8'h00;
    localparam logic [7:0] RSP_ERROR = 8'h01;
    localparam logic [7:0] RSP_FIRMWARE = 8'h02;
    localparam logic [7:0] RSP_CHIP = 8'h03;
    localparam logic [7:0] RSP_NOT_RECEIVED = 8'hFF;
    // Framing sizes
    localparam logic [4:0] TP_HDR_LAST = 5'h13;
    localparam logic [31:0] APP_HDR_BYTES = 32'h0000_0019;
    localparam logic [31:0] MAX_PAY = 32'h0000_0578;
    localparam logic [15:0] USER_MAX = 16'h0400;
    localparam logic [7:0] HDR_VERSION = 8'h01;
    localparam logic [15:0] TYPE_DIST_AMP = 16'h0000;
    localparam logic [15:0] TYPE_PHASE = 16'h0004;
    localparam logic [2:0] LANES_DIST = 3'h3;
    localparam logic [2:0] LANES_PHASE = 3'h7;
    // Pixel value limits and fault codes
    localparam logic [11:0] AMP_MAX = 12'hB4E;
    localparam logic [15:0] DIST_MAX = 16'hFA00;
    localparam logic [15:0] CODE_LOW_AMP = 16'hFA01;
    localparam logic [15:0] CODE_ADC_OVF = 16'hFA02;
    localparam logic [15:0] CODE_SATURATED = 16'hFA03;
    localparam logic [15:0] CODE_BAD_PIXEL = 16'hFA04;
    localparam logic [15:0] CODE_INTERFERENCE = 16'hFA07;
    localparam logic [15:0] CODE_EDGE = 16'hFA08;

    typedef enum logic [2:0] {
        PF_NONE = 3'b000, PF_LOW_AMP = 3'b001, PF_ADC_OVF = 3'b010,
        PF_SATURATED = 3'b011, PF_BAD_PIXEL = 3'b100, PF_INTERFERENCE = 3'b101,
        PF_EDGE = 3'b110
    } pixel_fault_e;

    typedef enum logic [2:0] {
        RK_ACK = 3'b000, RK_NOT_RECEIVED = 3'b001, RK_ERROR = 3'b010,
        RK_FIRMWARE = 3'b011, RK_CHIP = 3'b100
    } reply_kind_e;

    typedef enum logic [1:0] {
        F_IDLE = 2'b00, F_THDR = 2'b01, F_PAY = 2'b10
    } frame_state_e;

    typedef struct packed {
        pixel_fault_e fault;
        logic [11:0] amplitude;
        logic [13:0] distance;
        logic [47:0] phase_sample;
    } pixel_s;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_s;
endpackage : packetizer_pkg

// >>> hw/tof_measurement_udp_packetizer.sv
`timescale 1ns/10ps
module tof_measurement_udp_packetizer #(
    parameter int MAX_PAYLOAD = 1400
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] user_byte,
    input wire logic user_valid,
    output logic user_ready,
    input wire packetizer_pkg::pixel_s pix,
    input wire logic pix_valid,
    output logic pix_ready,
    output packetizer_pkg::byte_s pkt_out,
    output logic pkt_valid,
    input wire logic pkt_ready,
    output packetizer_pkg::byte_s rsp_out,
    output logic rsp_valid,
    input wire logic rsp_ready
);
    initial
    begin
        if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > 2047)
            $error("MAX_PAYLOAD must lie in 1..2047");
    end
    localparam logic [31:0] PAY_LIM = 32'(MAX_PAYLOAD);

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [5:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r, rd_mux;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] size_r, roi_a_r, roi_b_r, int_a_r, int_b_r, fmt_r, rarg_r;
    logic reject_r;
    logic do_write, rd_hit, wr_hit;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    endfunction : merge

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wr_hit = aw_addr_r <= packetizer_pkg::REG_REPLY_CMD && aw_addr_r[1:0] == 2'h0;
    assign rd_hit = s_axi_araddr <= packetizer_pkg::REG_REPLY_CMD
        && s_axi_araddr[1:0] == 2'h0;

    // Write address and data are captured independently
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= packetizer_pkg::RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_r)
                aw_addr_r <= s_axi_awaddr;
            if (s_axi_wvalid && !w_held_r)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= (aw_held_r && !do_write) || s_axi_awvalid;
            w_held_r <= (w_held_r && !do_write) || s_axi_wvalid;
            if (do_write)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? packetizer_pkg::RESP_OK : packetizer_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Read data mux
    logic busy;
    logic [15:0] cnt_r;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr == packetizer_pkg::REG_STATUS)
            rd_mux = {14'h0000, reject_r, busy, cnt_r};
        else if (s_axi_araddr == packetizer_pkg::REG_SIZE)
            rd_mux = size_r;
        else if (s_axi_araddr == packetizer_pkg::REG_ROI_A)
            rd_mux = roi_a_r;
        else if (s_axi_araddr == packetizer_pkg::REG_ROI_B)
            rd_mux = roi_b_r;
        else if (s_axi_araddr == packetizer_pkg::REG_INTEG_A)
            rd_mux = int_a_r;
        else if (s_axi_araddr == packetizer_pkg::REG_INTEG_B)
            rd_mux = int_b_r;
        else if (s_axi_araddr == packetizer_pkg::REG_FORMAT)
            rd_mux = fmt_r;
        else if (s_axi_araddr == packetizer_pkg::REG_REPLY_ARG)
            rd_mux = rarg_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= packetizer_pkg::RESP_OK;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? packetizer_pkg::RESP_OK : packetizer_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Settings registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            size_r <= 32'h0000_0000;
            roi_a_r <= 32'h0000_0000;
            roi_b_r <= 32'h0000_0000;
            int_a_r <= 32'h0000_0000;
            int_b_r <= 32'h0000_0000;
            fmt_r <= 32'h0000_0000;
            rarg_r <= 32'h0000_0000;
        end
        else if (do_write)
        begin
            if (aw_addr_r == packetizer_pkg::REG_SIZE)
                size_r <= merge(size_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_ROI_A)
                roi_a_r <= merge(roi_a_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_ROI_B)
                roi_b_r <= merge(roi_b_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_INTEG_A)
                int_a_r <= merge(int_a_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_INTEG_B)
                int_b_r <= merge(int_b_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_FORMAT)
                fmt_r <= merge(fmt_r, w_data_r, w_strb_r);
            else if (aw_addr_r == packetizer_pkg::REG_REPLY_ARG)
                rarg_r <= merge(rarg_r, w_data_r, w_strb_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command replies
    logic [39:0] rvec_r;
    logic [2:0] rlen_r, rpos_r;
    logic rbusy_r, rsp_go;
    logic [39:0] rvec_nxt;
    logic [2:0] rlen_nxt;
    logic rkind_ok;

    assign rsp_go = do_write && aw_addr_r == packetizer_pkg::REG_REPLY_CMD
        && w_strb_r[0] && !rbusy_r && rkind_ok;
    assign rsp_valid = rbusy_r;
    assign rsp_out.data = rvec_r[7:0];
    assign rsp_out.last = rpos_r == rlen_r;

    // Reply layout, 16-bit fields low byte first
    always_comb
    begin
        rkind_ok = 1'b1;
        rlen_nxt = 3'h0;
        rvec_nxt = {32'h0000_0000, packetizer_pkg::RSP_ACK};
        case (packetizer_pkg::reply_kind_e'(w_data_r[2:0]))
            packetizer_pkg::RK_ACK: rvec_nxt[7:0] = packetizer_pkg::RSP_ACK;
            packetizer_pkg::RK_NOT_RECEIVED:
                rvec_nxt[7:0] = packetizer_pkg::RSP_NOT_RECEIVED;
            packetizer_pkg::RK_ERROR:
            begin
                rvec_nxt = {16'h0000, rarg_r[15:0], packetizer_pkg::RSP_ERROR};
                rlen_nxt = 3'h2;
            end
            packetizer_pkg::RK_FIRMWARE:
            begin
                rvec_nxt = {rarg_r, packetizer_pkg::RSP_FIRMWARE};
                rlen_nxt = 3'h4;
            end
            packetizer_pkg::RK_CHIP:
            begin
                rvec_nxt = {rarg_r, packetizer_pkg::RSP_CHIP};
                rlen_nxt = 3'h4;
            end
            default: rkind_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rbusy_r <= 1'b0;
            rvec_r <= 40'h00_0000_0000;
            rlen_r <= 3'h0;
            rpos_r <= 3'h0;
        end
        else if (rsp_go)
        begin
            rbusy_r <= 1'b1;
            rvec_r <= rvec_nxt;
            rlen_r <= rlen_nxt;
            rpos_r <= 3'h0;
        end
        else if (rbusy_r && rsp_ready)
        begin
            rbusy_r <= !rsp_out.last;
            rvec_r <= {8'h00, rvec_r[39:8]};
            rpos_r <= rpos_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel encoding
    function automatic logic [15:0] fault_code(input packetizer_pkg::pixel_fault_e f);
        case (f)
            packetizer_pkg::PF_LOW_AMP: fault_code = packetizer_pkg::CODE_LOW_AMP;
            packetizer_pkg::PF_ADC_OVF: fault_code = packetizer_pkg::CODE_ADC_OVF;
            packetizer_pkg::PF_SATURATED: fault_code = packetizer_pkg::CODE_SATURATED;
            packetizer_pkg::PF_BAD_PIXEL: fault_code = packetizer_pkg::CODE_BAD_PIXEL;
            packetizer_pkg::PF_INTERFERENCE: fault_code = packetizer_pkg::CODE_INTERFERENCE;
            packetizer_pkg::PF_EDGE: fault_code = packetizer_pkg::CODE_EDGE;
            default: fault_code = 16'h0000;
        endcase
    endfunction : fault_code

    function automatic logic [63:0] encode(input packetizer_pkg::pixel_s p, input logic ph);
        logic bad;
        logic [15:0] code;
        bad = p.fault != packetizer_pkg::PF_NONE;
        code = fault_code(p.fault);
        encode = 64'h0000_0000_0000_0000;
        if (ph)
        begin
            for (int i = 0; i < 4; i++)
                encode[16*i +: 16] = bad ? code : {4'h0, p.phase_sample[12*i +: 12]};
        end
        else
        begin
            encode[15:0] = bad ? code : {2'b00, p.distance};
            if (bad)
                encode[31:16] = code;
            else if (p.amplitude > packetizer_pkg::AMP_MAX)
                encode[31:16] = packetizer_pkg::CODE_SATURATED;
            else
                encode[31:16] = {4'h0, p.amplitude};
        end
    endfunction : encode

    ////////////////////////////////////////////////////////////////////////
    // Measurement framer
    packetizer_pkg::frame_state_e st_r;
    logic [4:0] hpos_r;
    logic [10:0] ppos_r, plen_r;
    logic [31:0] off_r, total_r, npkt_r, pidx_r;
    logic [63:0] pix_r;
    logic [2:0] lane_r;
    logic ob_valid_r;
    packetizer_pkg::byte_s ob_r;

    logic phase, type_ok, go, start, adv, src_ok, step, in_app, in_user, plast, flast;
    logic [15:0] ulen;
    logic [31:0] body_base, total_nxt, rem_nxt, rest;
    logic [33:0] pix_bytes;
    logic [2:0] lane_top;
    logic [159:0] thdr_vec;
    logic [199:0] app_vec;
    logic [63:0] pix_enc;
    logic [7:0] pay_byte, byte_nxt;

    assign phase = fmt_r[15:0] == packetizer_pkg::TYPE_PHASE;
    assign ulen = fmt_r[31:16];
    assign type_ok = (phase || fmt_r[15:0] == packetizer_pkg::TYPE_DIST_AMP)
        && ulen <= packetizer_pkg::USER_MAX;
    assign go = do_write && aw_addr_r == packetizer_pkg::REG_CTRL && w_strb_r[0] && w_data_r[0];
    assign start = go && st_r == packetizer_pkg::F_IDLE && type_ok;
    assign busy = st_r != packetizer_pkg::F_IDLE;
    assign lane_top = phase ? packetizer_pkg::LANES_PHASE : packetizer_pkg::LANES_DIST;
    assign body_base = packetizer_pkg::APP_HDR_BYTES + {16'h0000, ulen};
    assign pix_bytes = {2'b00, 32'(size_r[15:0]) * 32'(size_r[31:16])} << (phase ? 3 : 2);
    assign total_nxt = body_base + pix_bytes[31:0];
    assign rest = total_r - off_r - 32'h0000_0001;
    assign rem_nxt = rest < PAY_LIM ? rest : PAY_LIM;
    assign in_app = off_r < packetizer_pkg::APP_HDR_BYTES;
    assign in_user = !in_app && off_r < body_base;
    assign adv = !ob_valid_r || pkt_ready;
    assign src_ok = st_r == packetizer_pkg::F_THDR || in_app
        || (in_user ? user_valid : (lane_r != 3'h0 || pix_valid));
    assign step = adv && busy && src_ok;
    assign plast = st_r == packetizer_pkg::F_PAY && ppos_r == plen_r - 11'h001;
    assign flast = plast && off_r + 32'h0000_0001 == total_r;
    assign user_ready = step && st_r == packetizer_pkg::F_PAY && in_user;
    assign pix_ready = step && st_r == packetizer_pkg::F_PAY && !in_app && !in_user
        && lane_r == 3'h0;
    assign pkt_valid = ob_valid_r;
    assign pkt_out = ob_r;

    // Transport header, 16/32-bit fields low byte first
    assign thdr_vec = {off_r, pidx_r, npkt_r, 5'h00, plen_r, total_r, cnt_r};
    // Metadata header in front of the data
    assign app_vec = {body_base[15:0], int_b_r[31:16], int_b_r[15:0], int_a_r[31:16],
        int_a_r[15:0], roi_b_r[31:16], roi_b_r[15:0], roi_a_r[31:16], roi_a_r[15:0],
        size_r[31:16], size_r[15:0], fmt_r[15:0], packetizer_pkg::HDR_VERSION};
    assign pix_enc = lane_r == 3'h0 ? encode(pix, phase) : pix_r;
    assign pay_byte = in_app ? app_vec[8*off_r[4:0] +: 8]
        : in_user ? user_byte : pix_enc[8*lane_r +: 8];
    assign byte_nxt = st_r == packetizer_pkg::F_THDR ? thdr_vec[8*hpos_r +: 8] : pay_byte;

    // Output byte register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ob_valid_r <= 1'b0;
            ob_r <= '0;
        end
        else if (adv)
        begin
            ob_valid_r <= step;
            ob_r.data <= byte_nxt;
            ob_r.last <= plast;
        end
    end

    // Refused start flag: any start not accepted, busy or bad format
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reject_r <= 1'b0;
        else if (start)
            reject_r <= 1'b0;
        else if (go)
            reject_r <= 1'b1;
    end

    // Packet and measurement sequencing
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r <= packetizer_pkg::F_IDLE;
            hpos_r <= 5'h00;
            ppos_r <= 11'h000;
            plen_r <= 11'h000;
            off_r <= 32'h0000_0000;
            total_r <= 32'h0000_0000;
            npkt_r <= 32'h0000_0000;
            pidx_r <= 32'h0000_0000;
            cnt_r <= 16'h0000;
            lane_r <= 3'h0;
            pix_r <= 64'h0000_0000_0000_0000;
        end
        else if (start)
        begin
            st_r <= packetizer_pkg::F_THDR;
            total_r <= total_nxt;
            npkt_r <= (total_nxt + PAY_LIM - 32'h0000_0001) / PAY_LIM;
            plen_r <= 11'(total_nxt < PAY_LIM ? total_nxt : PAY_LIM);
            hpos_r <= 5'h00;
            off_r <= 32'h0000_0000;
            pidx_r <= 32'h0000_0000;
            lane_r <= 3'h0;
        end
        else if (step && st_r == packetizer_pkg::F_THDR)
        begin
            hpos_r <= hpos_r + 5'h01;
            ppos_r <= 11'h000;
            if (hpos_r == packetizer_pkg::TP_HDR_LAST)
                st_r <= packetizer_pkg::F_PAY;
        end
        else if (step)
        begin
            off_r <= off_r + 32'h0000_0001;
            ppos_r <= ppos_r + 11'h001;
            if (!in_app && !in_user)
            begin
                lane_r <= lane_r == lane_top ? 3'h0 : lane_r + 3'h1;
                if (lane_r == 3'h0)
                    pix_r <= pix_enc;
            end
            if (plast)
            begin
                pidx_r <= pidx_r + 32'h0000_0001;
                hpos_r <= 5'h00;
                plen_r <= rem_nxt[10:0];
                st_r <= flast ? packetizer_pkg::F_IDLE : packetizer_pkg::F_THDR;
                if (flast)
                    cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_payload_len_bound: assert property (@(posedge sys_clk) disable iff (rst)
        busy |-> plen_r != 11'h000 && 32'(plen_r) <= PAY_LIM)
        else $error("Packet payload length out of range");

    a_header_twenty_bytes: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(st_r == packetizer_pkg::F_PAY) |-> $past(hpos_r) == packetizer_pkg::TP_HDR_LAST)
        else $error("Transport header not twenty bytes");

    a_counter_per_frame: assert property (@(posedge sys_clk) disable iff (rst)
        (step && flast) |=> cnt_r == $past(cnt_r) + 16'h0001 && !busy)
        else $error("Measurement counter did not advance");

    a_index_ascends: assert property (@(posedge sys_clk) disable iff (rst)
        (step && plast && !flast) |=> st_r == packetizer_pkg::F_THDR
            && pidx_r == $past(pidx_r) + 32'h0000_0001 && hpos_r == 5'h00)
        else $error("Packet index did not ascend");

    a_offset_tracks: assert property (@(posedge sys_clk) disable iff (rst)
        (step && st_r == packetizer_pkg::F_PAY) |=> off_r == $past(off_r) + 32'h0000_0001)
        else $error("Payload offset out of step");

    a_last_index: assert property (@(posedge sys_clk) disable iff (rst)
        (step && flast) |-> pidx_r == npkt_r - 32'h0000_0001)
        else $error("Final packet index differs from packet total");

    a_version_first: assert property (@(posedge sys_clk) disable iff (rst)
        (step && st_r == packetizer_pkg::F_PAY && off_r == 32'h0000_0000)
            |=> pkt_valid && pkt_out.data == packetizer_pkg::HDR_VERSION)
        else $error("Payload does not open with version");

    a_amp_in_range: assert property (@(posedge sys_clk) disable iff (rst)
        (pix_ready && !phase) |-> pix_enc[31:16] <= {4'h0, packetizer_pkg::AMP_MAX}
            || pix_enc[31:16] > packetizer_pkg::DIST_MAX)
        else $error("Amplitude neither valid nor a fault code");

    a_not_received_code: assert property (@(posedge sys_clk) disable iff (rst)
        (rsp_go && w_data_r[2:0] == packetizer_pkg::RK_NOT_RECEIVED) |=> rsp_valid
            && rsp_out.last && rsp_out.data == packetizer_pkg::RSP_NOT_RECEIVED)
        else $error("Not-received reply malformed");

    a_error_reply_len: assert property (@(posedge sys_clk) disable iff (rst)
        (rsp_go && w_data_r[2:0] == packetizer_pkg::RK_ERROR) |=> rlen_r == 3'h2
            && rsp_out.data == packetizer_pkg::RSP_ERROR)
        else $error("Error reply malformed");
endmodule : tof_measurement_udp_packetizer

// >>> verif/host_rx.sv
`timescale 1ns/10ps
// Host receiver: keeps the packet stream in arrival order, stalls one cycle in four
module host_rx (
    input wire logic sys_clk,
    input wire logic rst,
    input wire packetizer_pkg::byte_s pkt_out,
    input wire logic pkt_valid,
    output logic pkt_ready
);
    logic [7:0] mem [0:255];
    logic [7:0] n_r;
    logic [1:0] cyc_r;
    // Capture with back-pressure
    always_ff @(posedge sys_clk)
    begin
        cyc_r <= rst ? 2'h0 : cyc_r + 2'h1;
        pkt_ready <= !rst && (cyc_r != 2'h3);
        if (rst)
            n_r <= 8'h00;
        else if (pkt_valid && pkt_ready)
        begin
            mem[n_r] <= pkt_out.data;
            n_r <= n_r + 8'h01;
        end
    end
endmodule : host_rx

// >>> verif/tb_tof_measurement_udp_packetizer.sv
`timescale 1ns/10ps
module tb_tof_measurement_udp_packetizer;
    logic sys_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pix_valid = 1'b0, ta, tw;
    logic awready, wready, bvalid, arready, rvalid, user_ready, pix_ready;
    logic pkt_valid, pkt_ready, rsp_valid;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, rr;
    logic [7:0] rsp_q [$];
    logic [7:0] exp_r [15] = '{8'h00, 8'hFF, 8'h01, 8'h03, 8'h00, 8'h02, 8'h03, 8'h00,
        8'h04, 8'h00, 8'h03, 8'h03, 8'h00, 8'h04, 8'h00};
    logic [15:0] tab [15] = '{16'h021D, 16'h0608, 16'h0804, 16'h1401, 16'h1701, 16'h2C08,
        16'h5A05, 16'h6003, 16'h6418, 16'h69D2, 16'h6A04, 16'h6B64, 16'h6D01, 16'hD604,
        16'hD7FA};
    packetizer_pkg::pixel_s pix = '{packetizer_pkg::PF_NONE, 12'h064, 14'h04D2, 48'h0};
    packetizer_pkg::byte_s pkt_out, rsp_out;
    int n_mismatch = 0, n_checks = 0;

    tof_measurement_udp_packetizer #(.MAX_PAYLOAD(8)) tof_measurement_udp_packetizer_inst (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .user_byte(8'h00), .user_valid(1'b0), .user_ready(user_ready), .pix(pix),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pkt_out(pkt_out),
        .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .rsp_out(rsp_out),
        .rsp_valid(rsp_valid), .rsp_ready(1'b1));
    host_rx host_rx_inst (.sys_clk(sys_clk), .rst(rst), .pkt_out(pkt_out),
        .pkt_valid(pkt_valid), .pkt_ready(pkt_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and reply byte capture
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk)
    begin
        if (rsp_valid)
            rsp_q.push_back(rsp_out.data);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Bus write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        do
        begin
            @(negedge sys_clk);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge sys_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        while (!(ta && tw));
        @(negedge sys_clk);
        while (!bvalid) @(negedge sys_clk);
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge sys_clk);
        while (!arready) @(negedge sys_clk);
        @(posedge sys_clk);
        arvalid <= 1'b0;
        @(negedge sys_clk);
        while (!rvalid) @(negedge sys_clk);
        d = rdata;
        rr = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Replies of every kind, then two one-pixel measurements in four packets each
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wr(packetizer_pkg::REG_REPLY_ARG, 32'h0004_0003);
        for (int k = 0; k < 5; k++)
        begin
            wr(packetizer_pkg::REG_REPLY_CMD, 32'(k));
            @(negedge sys_clk);
            while (rsp_valid) @(negedge sys_clk);
        end
        foreach (exp_r[i]) chk(32'(rsp_q[i]), 32'(exp_r[i]));
        wr(packetizer_pkg::REG_SIZE, 32'h0001_0001);
        wr(packetizer_pkg::REG_FORMAT, 32'h0000_0000);
        pix_valid <= 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            wr(packetizer_pkg::REG_CTRL, 32'h0000_0001);
            @(negedge sys_clk);
            while (host_rx_inst.n_r != 8'(109 * m + 109)) @(negedge sys_clk);
            @(posedge sys_clk);
            pix.fault <= packetizer_pkg::PF_BAD_PIXEL;
        end
        foreach (tab[i]) chk(32'(host_rx_inst.mem[tab[i][15:8]]), 32'(tab[i][7:0]));
        wr(packetizer_pkg::REG_FORMAT, 32'h0000_0002);
        wr(packetizer_pkg::REG_CTRL, 32'h0000_0001);
        rd(packetizer_pkg::REG_STATUS);
        chk(32'(d[15:0]), 32'h0000_0002);
        chk(32'(d[17:16]), 32'h0000_0002);
        rd(6'h28);
        chk(32'(rr), 32'(packetizer_pkg::RESP_SLVERR));
        final_report;
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        final_report;
    end
endmodule : tb_tof_measurement_udp_packetizer
